// File: rtl/bdt_cfg.svh
`ifndef BDT_CFG_SVH
`define BDT_CFG_SVH
// Register byte offsets
`define BDT_OFF_CONTROL      12'h000
`define BDT_OFF_CHANNEL      12'h004
`define BDT_OFF_STATUS       12'h008
// Control register field positions
`define BDT_DT_LSB           0
`define BDT_DT_MSB           7
`define BDT_LOCK_LSB         8
`define BDT_LOCK_MSB         9
`define BDT_IDLE_OFF_BIT     10
`define BDT_RUN_OFF_BIT      11
`define BDT_BRK_EN_BIT       12
`define BDT_BRK_POL_BIT      13
`define BDT_AUTO_BIT         14
`define BDT_MOE_BIT          15
`define BDT_DIRECT_BIT       16
`define BDT_CONTROL_RESET    32'h0000_0000
// Channel register layout, four bits per channel:
// true enable, true polarity, comp enable, comp polarity; idle levels at 16 + 2*ch
`define BDT_CH_STRIDE        4
`define BDT_IDLE_BASE        16
`define BDT_CHANNEL_RESET    32'h0000_0000
`endif

// File: rtl/bdt_pkg.sv
package bdt_pkg;
  typedef enum logic [1:0] {
    LOCK_OFF,
    LOCK_L1,
    LOCK_L2,
    LOCK_L3
  } lock_level_e;
  typedef enum logic [1:0] {
    OUT_RUN,
    OUT_BREAK_WAIT,
    OUT_IDLE
  } out_state_e;
endpackage : bdt_pkg

// File: rtl/break_deadtime_output_control.sv
`timescale 1ns/1ns
`include "bdt_cfg.svh"
module break_deadtime_output_control #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Timer core
  input  wire logic                  update_event,
  input  wire logic [CHANNELS-1:0]   ref_active,
  // Break pin, asynchronous
  input  wire logic                  break_in,
  // Power stage
  output logic      [CHANNELS-1:0]   true_channel_output,
  output logic      [CHANNELS-1:0]   true_channel_oe,
  output logic      [CHANNELS-1:0]   complementary_channel_output,
  output logic      [CHANNELS-1:0]   complementary_channel_oe
);

  // Break synchroniser
  logic                      brk_meta;
  logic                      brk_sync;
  logic                      brk_active_q;
  logic [31:0]               control;
  logic [31:0]               channel;
  logic                      first_write_done;
  bdt_pkg::out_state_e       out_state;
  logic [7:0]                brk_count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_meta <= 1'b0;
      brk_sync <= 1'b0;
    end else begin
      brk_meta <= break_in;
      brk_sync <= brk_meta;
    end
  end

  // Register fields
  wire logic [7:0]  dead_time_value        = control[`BDT_DT_MSB:`BDT_DT_LSB];
  wire logic [1:0]  lock_level             = control[`BDT_LOCK_MSB:`BDT_LOCK_LSB];
  wire logic        idle_off_state_select  = control[`BDT_IDLE_OFF_BIT];
  wire logic        run_off_state_select   = control[`BDT_RUN_OFF_BIT];
  wire logic        break_enable           = control[`BDT_BRK_EN_BIT];
  wire logic        break_polarity         = control[`BDT_BRK_POL_BIT];
  wire logic        auto_output_rearm      = control[`BDT_AUTO_BIT];
  wire logic        main_output_enable     = control[`BDT_MOE_BIT];
  wire logic        direct_idle_on_break   = control[`BDT_DIRECT_BIT];

  wire logic brk_level  = break_polarity ? brk_sync : ~brk_sync;
  wire logic brk_active = break_enable & brk_level;
  wire logic brk_rise   = brk_active & ~brk_active_q;

  // Lock decode
  wire logic lock_ge1 = (lock_level != 2'(bdt_pkg::LOCK_OFF));
  wire logic lock_ge2 = (lock_level == 2'(bdt_pkg::LOCK_L2)) | (lock_level == 2'(bdt_pkg::LOCK_L3));
  wire logic lock_ge3 = (lock_level == 2'(bdt_pkg::LOCK_L3));

  // APB decode
  wire logic        apb_access = psel & penable;
  wire logic        apb_write  = apb_access & pwrite;
  wire logic        hit_ctrl   = (paddr == `BDT_OFF_CONTROL);
  wire logic        hit_chan   = (paddr == `BDT_OFF_CHANNEL);
  wire logic        hit_stat   = (paddr == `BDT_OFF_STATUS);
  wire logic        unmapped   = ~(hit_ctrl | hit_chan | hit_stat);
  wire logic [31:0] byte_mask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Read-only mask of the control register per lock level; lock field read-only after the first write
  wire logic [31:0] ctrl_lock_mask =
      ({15'h0000, 1'b1, 16'h0000} & {32{lock_ge1}}) |
      ({16'h0000, 4'h7, 12'h000}  & {32{lock_ge1}}) |
      ({24'h00_0000, 8'hff}       & {32{lock_ge1}}) |
      ({20'h0_0000, 4'hc, 8'h00}  & {32{lock_ge2}}) |
      ({22'h00_0000, 2'h3, 8'h00} & {32{first_write_done}});
  wire logic [31:0] ctrl_wmask = byte_mask & ~ctrl_lock_mask & 32'h0001_ffff;

  // Channel register mask: idle levels at L1, polarities at L2, enables at L3
  logic [31:0] chan_lock_mask;
  always_comb begin
    chan_lock_mask = 32'h0000_0000;
    for (int i = 0; i < CHANNELS; i++) begin
      chan_lock_mask[`BDT_CH_STRIDE*i]     = lock_ge3;
      chan_lock_mask[`BDT_CH_STRIDE*i + 1] = lock_ge2;
      chan_lock_mask[`BDT_CH_STRIDE*i + 2] = lock_ge3;
      chan_lock_mask[`BDT_CH_STRIDE*i + 3] = lock_ge2;
      chan_lock_mask[`BDT_IDLE_BASE + 2*i]     = lock_ge1;
      chan_lock_mask[`BDT_IDLE_BASE + 2*i + 1] = lock_ge1;
    end
  end
  logic [31:0] chan_used;
  always_comb begin
    chan_used = 32'h0000_0000;
    for (int i = 0; i < CHANNELS; i++) begin
      chan_used[`BDT_CH_STRIDE*i +: 4]   = 4'hf;
      chan_used[`BDT_IDLE_BASE + 2*i +: 2] = 2'h3;
    end
  end
  wire logic [31:0] chan_wmask = byte_mask & ~chan_lock_mask & chan_used;

  // Main output enable next value
  wire logic sw_ctrl_wr = apb_write & hit_ctrl;
  wire logic moe_sw_val = sw_ctrl_wr & pstrb[1] ? pwdata[`BDT_MOE_BIT] : main_output_enable;
  wire logic moe_auto   = auto_output_rearm & update_event & ~brk_active;
  wire logic next_moe   = brk_active ? 1'b0 : (moe_auto | moe_sw_val);

  wire logic [31:0] ctrl_written = (control & ~ctrl_wmask) | (pwdata & ctrl_wmask);
  wire logic [31:0] next_control = sw_ctrl_wr ?
      {ctrl_written[31:`BDT_MOE_BIT+1], next_moe, ctrl_written[`BDT_MOE_BIT-1:0]} :
      {control[31:`BDT_MOE_BIT+1], next_moe, control[`BDT_MOE_BIT-1:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control          <= `BDT_CONTROL_RESET;
      channel          <= `BDT_CHANNEL_RESET;
      first_write_done <= 1'b0;
      brk_active_q     <= 1'b0;
    end else begin
      control      <= next_control;
      brk_active_q <= brk_active;
      if (sw_ctrl_wr) begin
        first_write_done <= 1'b1;
      end
      if (apb_write & hit_chan) begin
        channel <= (channel & ~chan_wmask) | (pwdata & chan_wmask);
      end
    end
  end

  // Break sequencing: optional dead-time wait before idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_state <= bdt_pkg::OUT_IDLE;
      brk_count <= 8'h00;
    end else begin
      case (out_state)
        bdt_pkg::OUT_RUN: begin
          if (brk_rise & ~direct_idle_on_break) begin
            out_state <= bdt_pkg::OUT_BREAK_WAIT;
            brk_count <= dead_time_value;
          end else if (~main_output_enable) begin
            out_state <= bdt_pkg::OUT_IDLE;
          end
        end
        bdt_pkg::OUT_BREAK_WAIT: begin
          if (brk_count == 8'h00) begin
            out_state <= bdt_pkg::OUT_IDLE;
          end else begin
            brk_count <= brk_count - 8'h01;
          end
        end
        bdt_pkg::OUT_IDLE: begin
          if (main_output_enable) begin
            out_state <= bdt_pkg::OUT_RUN;
          end
        end
        default: out_state <= bdt_pkg::OUT_IDLE;
      endcase
    end
  end

  wire logic run_mode = (out_state != bdt_pkg::OUT_IDLE);

  // Per-channel output stage with dead-time on both edges of ref_active
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      wire logic te   = channel[`BDT_CH_STRIDE*g];
      wire logic tp   = channel[`BDT_CH_STRIDE*g + 1];
      wire logic ce   = channel[`BDT_CH_STRIDE*g + 2];
      wire logic cp   = channel[`BDT_CH_STRIDE*g + 3];
      wire logic tidl = channel[`BDT_IDLE_BASE + 2*g];
      wire logic cidl = channel[`BDT_IDLE_BASE + 2*g + 1];
      logic       ref_q;
      logic [7:0] dt_cnt;
      wire logic  edge_seen = (ref_active[g] != ref_q);
      wire logic  dt_busy   = (dt_cnt != 8'h00);
      // Raw active levels after dead-time insertion
      wire logic  t_act = ref_q & ~dt_busy & ~edge_seen;
      wire logic  c_act = ~ref_q & ~dt_busy & ~edge_seen;
      wire logic  comp_mode = te & ce;
      // Run mode: enabled channels drive; off-state select keeps the inactive level driven
      wire logic  t_run_oe = te | (run_off_state_select & ce);
      wire logic  c_run_oe = ce | (run_off_state_select & te);
      wire logic  t_run_lv = (te ? (comp_mode ? t_act : ref_active[g]) : 1'b0) ^ tp;
      wire logic  c_run_lv = (ce ? (comp_mode ? c_act : ~ref_active[g]) : 1'b0) ^ cp;
      // Idle mode: off-state idle select drives idle levels, else outputs released
      wire logic  idle_oe  = idle_off_state_select & (te | ce);
      wire logic  next_t_oe = run_mode ? t_run_oe : idle_oe;
      wire logic  next_c_oe = run_mode ? c_run_oe : idle_oe;
      wire logic  next_t_lv = run_mode ? t_run_lv : tidl;
      wire logic  next_c_lv = run_mode ? c_run_lv : cidl;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ref_q                           <= 1'b0;
          dt_cnt                          <= 8'h00;
          true_channel_output[g]          <= 1'b0;
          true_channel_oe[g]              <= 1'b0;
          complementary_channel_output[g] <= 1'b0;
          complementary_channel_oe[g]     <= 1'b0;
        end else begin
          ref_q <= ref_active[g];
          if (edge_seen) begin
            dt_cnt <= dead_time_value;
          end else if (dt_busy) begin
            dt_cnt <= dt_cnt - 8'h01;
          end
          true_channel_output[g]          <= next_t_lv;
          true_channel_oe[g]              <= next_t_oe;
          complementary_channel_output[g] <= next_c_lv;
          complementary_channel_oe[g]     <= next_c_oe;
        end
      end
    end
  endgenerate

  // APB read and response
  wire logic [31:0] status_word = {28'h000_0000, brk_sync, brk_active, run_mode, first_write_done};
  wire logic [31:0] next_prdata = hit_ctrl ? control :
                                  hit_chan ? channel :
                                  hit_stat ? status_word : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & unmapped;
      if (psel & ~penable & ~pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule : break_deadtime_output_control

// File: test/bdt_checker_properties.sv
`timescale 1ns/1ns
`include "bdt_cfg.svh"
module bdt_checker #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Power stage enables
  input wire logic [CHANNELS-1:0] true_channel_oe,
  input wire logic [CHANNELS-1:0] complementary_channel_oe
);
  logic ctl_written;
  wire  setup  = psel && !penable;
  wire  mapped = paddr == `BDT_OFF_CONTROL || paddr == `BDT_OFF_CHANNEL || paddr == `BDT_OFF_STATUS;
  wire  ctl_wr = psel && penable && pready && pwrite && paddr == `BDT_OFF_CONTROL;
  // Main enable stays off until software first writes the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_written <= 1'b0;
    else if (ctl_wr) ctl_written <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_after_setup; setup |=> pready && psel && penable; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_in_access; pready |-> psel && penable; endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_err_unmapped; setup && !mapped |=> pslverr; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  property p_ok_mapped; setup && mapped |=> !pslverr; endproperty
  a_ok_mapped: assert property (p_ok_mapped) else $error("mapped access refused");
  property p_err_with_ready; pslverr |-> pready; endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_unmapped_zero; pready && pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_off_before_config; !ctl_written |-> true_channel_oe == '0 && complementary_channel_oe == '0; endproperty
  a_off_before_config: assert property (p_off_before_config) else $error("outputs on before config");
  c_write: cover property (setup && pwrite ##1 pready);
  c_read: cover property (setup && !pwrite ##1 pready);
  c_refused: cover property (pready && pslverr);
endmodule : bdt_checker

bind break_deadtime_output_control bdt_checker #(.CHANNELS(CHANNELS)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .true_channel_oe(true_channel_oe),
  .complementary_channel_oe(complementary_channel_oe));

// File: test/break_source.sv
`timescale 1ns/1ns
module break_source (
  // Trip request and level sense
  input  wire logic trip,
  input  wire logic active_high,
  // Break pin
  output logic      break_pin
);
  // Shows the active level only while tripped
  assign break_pin = trip ? active_high : !active_high;
endmodule : break_source

// File: test/break_deadtime_output_control_test.sv
`timescale 1ns/1ns
`include "bdt_cfg.svh"
module break_deadtime_output_control_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hf;
  logic        update_event = 1'b0;
  logic [3:0]  ref_active = 4'h0;
  logic        trip = 1'b0;
  logic        active_high = 1'b0;
  logic        break_in;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  true_out;
  logic [3:0]  true_oe;
  logic [3:0]  comp_out;
  logic [3:0]  comp_oe;
  logic [31:0] rd;
  logic        err;
  int          n;
  int          fails = 0;
  int          checks = 0;
  always #50 pclk = ~pclk;
  break_deadtime_output_control #(.CHANNELS(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .update_event(update_event), .ref_active(ref_active), .break_in(break_in),
    .true_channel_output(true_out), .true_channel_oe(true_oe),
    .complementary_channel_output(comp_out), .complementary_channel_oe(comp_oe));
  break_source src_u (.trip(trip), .active_high(active_high), .break_pin(break_in));
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      fails++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e_exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0000_0000, err}, {31'h0000_0000, e_exp});
  endtask : rd_chk
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  task automatic update_trip(input logic t);
    trip <= t;
    repeat (4) @(posedge pclk);
    update_event <= 1'b1;
    @(posedge pclk);
    update_event <= 1'b0;
  endtask : update_trip
  initial begin
    do_reset();
    rd_chk(`BDT_OFF_CONTROL, `BDT_CONTROL_RESET, 1'b0);
    rd_chk(`BDT_OFF_CHANNEL, `BDT_CHANNEL_RESET, 1'b0);
    rd_chk(12'h0fc, 32'h0000_0000, 1'b1);
    rd_chk(`BDT_OFF_STATUS, 32'h0000_0008, 1'b0);
    apb(1'b1, `BDT_OFF_CONTROL, 32'h0000_5005);
    update_trip(1'b0);
    rd_chk(`BDT_OFF_CONTROL, 32'h0000_d005, 1'b0);
    update_trip(1'b1);
    rd_chk(`BDT_OFF_CONTROL, 32'h0000_5005, 1'b0);
    update_trip(1'b0);
    rd_chk(`BDT_OFF_CONTROL, 32'h0000_d005, 1'b0);
    apb(1'b1, `BDT_OFF_CONTROL, 32'h0000_4005);
    update_trip(1'b1);
    rd_chk(`BDT_OFF_CONTROL, 32'h0000_c005, 1'b0);
    trip <= 1'b0;
    apb(1'b1, `BDT_OFF_CHANNEL, 32'h0000_0005);
    ref_active <= 4'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (true_out[0] !== 1'b1 && n < 40);
    chk({31'h0000_0000, n >= 6 && n <= 10}, 32'h0000_0001);
    chk({24'h00_0000, comp_oe, true_oe}, 32'h0000_0011);
    chk({28'h000_0000, comp_out}, 32'h0000_0000);
    apb(1'b1, `BDT_OFF_CHANNEL, 32'h0000_0007);
    repeat (4) @(posedge pclk);
    chk({28'h000_0000, true_out}, 32'h0000_0000);
    ref_active <= 4'h0;
    active_high <= 1'b1;
    do_reset();
    apb(1'b1, `BDT_OFF_CONTROL, 32'h0000_b105);
    rd_chk(`BDT_OFF_CONTROL, 32'h0000_b105, 1'b0);
    apb(1'b1, `BDT_OFF_CONTROL, 32'h0000_0f00);
    rd_chk(`BDT_OFF_CONTROL, 32'h0000_3d05, 1'b0);
    apb(1'b1, `BDT_OFF_CHANNEL, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    chk({28'h000_0000, true_oe}, 32'h0000_0001);
    apb(1'b1, `BDT_OFF_CONTROL, 32'h0000_8000);
    rd_chk(`BDT_OFF_CONTROL, 32'h0000_b105, 1'b0);
    update_trip(1'b1);
    rd_chk(`BDT_OFF_CONTROL, 32'h0000_3105, 1'b0);
    complete_run();
  end
endmodule : break_deadtime_output_control_test
